// ### inc/ple_pkg.sv
// package: constants and carriers for the logic cell group
package ple_pkg;

  // ----------------------------------------
  // sizes and register map
  // ----------------------------------------
  localparam int          NCELL    = 10;
  localparam int          MID      = 5;
  localparam logic [7:0]  A_CTRL   = 8'h00;
  localparam logic [7:0]  A_STAT   = 8'h04;
  localparam logic [7:0]  A_CFG    = 8'h40;
  localparam logic [31:0] RD_ZERO  = 32'h0000_0000;

  // ----------------------------------------
  // field types
  // ----------------------------------------
  typedef enum logic [1:0] {FF_D, FF_T, FF_JK, FF_SR} ple_ff_t;

  typedef struct packed {
    logic [20:0] rsv;
    logic        reinit;
    logic        pin_en;
    logic        aload;
    logic        preset;
    logic        aclr1;
    logic        aclr0;
    logic        sload;
    logic        sclr;
    logic        ce1;
    logic        ce0;
    logic        sub;
  } ple_ctrl_t;

  typedef struct packed {
    logic        rsv;
    logic        pwr_hi;
    logic        ce_sel;
    logic        clr_sel;
    logic        cnt;
    logic        start;
    logic        rchain;
    logic        lchain;
    logic        pack;
    logic        cin_sel;
    logic        arith;
    logic [2:0]  osel;
    ple_ff_t     ff;
    logic [15:0] mask;
  } ple_cfg_t;

  typedef struct packed {
    ple_ctrl_t              ctrl;
    ple_cfg_t [NCELL-1:0]   cfg;
    logic [NCELL-1:0]       q;
    logic [3*NCELL-1:0]     gen;
    logic [NCELL-1:0]       comb;
    logic                   lchain;
    logic                   rchain;
    logic                   cout;
    logic                   ack;
    logic [31:0]            dat;
  } ple_state_t;

  localparam ple_state_t ST_RST = '0;

endpackage

// ### verilog/ple_cell_group.sv
// module: ten logic cells with group control and a wishbone register port
`timescale 1ns/100ps
module ple_cell_group (
  input  wire logic        clk_i,               // 25 MHz clock
  input  wire logic        rst_i,               // sync reset, high
  input  wire logic        cyc_i,               // wishbone cycle
  input  wire logic        stb_i,               // wishbone strobe
  input  wire logic        we_i,                // wishbone write
  input  wire logic [7:0]  adr_i,               // byte address
  input  wire logic [3:0]  sel_i,               // byte lanes
  input  wire logic [31:0] dat_i,               // write data
  output logic      [31:0] dat_o,               // read data
  output logic             ack_o,               // wishbone ack
  input  wire logic [39:0] data_i,              // four data inputs per cell
  input  wire logic        carry_in_i,          // carry from previous group
  input  wire logic        lut_chain_i,         // table chain into cell 0
  input  wire logic        reg_chain_i,         // register chain into cell 0
  input  wire logic        chip_wide_clear_n_i, // chip clear pin, low
  output logic      [29:0] gen_o,               // three outputs per cell
  output logic      [9:0]  comb_o,              // cell results, registered one edge late
  output logic      [9:0]  q_o,                 // register outputs
  output logic             lut_chain_o,         // table chain out
  output logic             reg_chain_o,         // register chain out
  output logic             carry_out_o          // carry to next group
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  ple_pkg::ple_state_t s;
  ple_pkg::ple_state_t n;
  ple_pkg::ple_cfg_t   cf;
  ple_pkg::ple_ctrl_t  wc;

  logic       hit;
  logic       cfg_hit;
  logic [3:0] cidx;
  logic [3:0] d;
  logic       grp_cin;
  logic       blk;
  logic       pin_hit;
  logic       carry_in_zero_chain;
  logic       carry_in_one_chain;
  logic       carry_out_zero_chain;
  logic       carry_out_one_chain;
  logic       fourth_data_input;
  logic       sub;
  logic       a;
  logic       b;
  logic       sum0;
  logic       sum1;
  logic       in0;
  logic       in2;
  logic       in3;
  logic       lut;
  logic       res;
  logic       din;
  logic       ce;
  logic       clr;
  logic       nq;
  logic       pq;
  logic       pl;

  // byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wr,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int k = 0; k < 4; k++) begin
      if (be[k]) begin
        r[8*k +: 8] = wr[8*k +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin
    n       = s;
    cf      = s.cfg[0];
    wc      = s.ctrl;
    d       = 4'h0;
    hit     = cyc_i && stb_i && !s.ack;
    cidx    = adr_i[5:2];
    cfg_hit = (adr_i[7:6] == ple_pkg::A_CFG[7:6]) && (cidx < 4'(ple_pkg::NCELL));

    // ----------------------------------------
    // register port: one ack per request, registered one cycle after it
    // ----------------------------------------
    n.ack         = hit;
    n.dat         = ple_pkg::RD_ZERO;
    n.ctrl.reinit = 1'b0;
    if (hit && we_i) begin
      if (adr_i == ple_pkg::A_CTRL) begin
        wc        = merge(s.ctrl, dat_i, sel_i);
        wc.rsv    = '0;
        n.ctrl    = wc;
      end else if (cfg_hit) begin
        cf         = merge(s.cfg[cidx], dat_i, sel_i);
        cf.rsv     = 1'b0;
        n.cfg[cidx] = cf;
      end
    end else if (hit) begin
      if (adr_i == ple_pkg::A_CTRL) begin
        n.dat = s.ctrl;
      end else if (adr_i == ple_pkg::A_STAT) begin
        n.dat = {14'h0000, s.cout, chip_wide_clear_n_i, 6'h00, s.q};
      end else if (cfg_hit) begin
        n.dat = s.cfg[cidx];
      end
    end

    // ----------------------------------------
    // cell array
    // ----------------------------------------
    pin_hit              = s.ctrl.pin_en && !chip_wide_clear_n_i;
    grp_cin              = s.ctrl.sub | carry_in_i;
    blk                  = grp_cin;
    carry_in_zero_chain  = 1'b0;
    carry_in_one_chain   = 1'b1;
    carry_out_zero_chain = 1'b0;
    carry_out_one_chain  = 1'b1;
    fourth_data_input    = 1'b0;
    pq                   = reg_chain_i;
    pl                   = lut_chain_i;
    sub                  = 1'b0;
    a                    = 1'b0;
    b                    = 1'b0;
    sum0                 = 1'b0;
    sum1                 = 1'b0;
    in0                  = 1'b0;
    in2                  = 1'b0;
    in3                  = 1'b0;
    lut                  = 1'b0;
    res                  = 1'b0;
    din                  = 1'b0;
    ce                   = 1'b0;
    clr                  = 1'b0;
    nq                   = 1'b0;
    for (int i = 0; i < ple_pkg::NCELL; i++) begin
      cf                = s.cfg[i];
      d                 = data_i[4*i +: 4];
      fourth_data_input = d[3];
      // upper half re-selects the block carry from the fifth cell's carries
      if (i == ple_pkg::MID) begin
        blk = blk ? carry_in_one_chain : carry_in_zero_chain;
      end
      if (cf.start) begin
        carry_in_zero_chain = 1'b0;
        carry_in_one_chain  = 1'b1;
      end

      // arithmetic: operand b inverted while subtracting
      sub  = cf.arith && s.ctrl.sub;
      // operands come from the second and third data inputs, or from the register and fourth input in count mode
      a    = cf.cnt ? s.q[i] : d[1];
      b    = (cf.cnt ? d[3] : d[2]) ^ sub;
      sum0 = a ^ b ^ carry_in_zero_chain;
      sum1 = a ^ b ^ carry_in_one_chain;
      carry_out_zero_chain = carry_in_zero_chain ? (a | b) : (a & b);
      carry_out_one_chain  = carry_in_one_chain ? (a | b) : (a & b);

      // normal mode table
      in0 = cf.lchain ? pl : d[0];
      in2 = cf.pack ? s.q[i] : d[2];
      in3 = cf.cin_sel ? blk : fourth_data_input;
      lut = cf.mask[{in3, in2, d[1], in0}];
      res = cf.arith ? (blk ? sum1 : sum0) : lut;

      // register next value
      din = cf.rchain ? pq : res;
      ce  = (cf.ce_sel ? s.ctrl.ce1 : s.ctrl.ce0) && !(cf.arith && cf.cnt && !d[2]);
      clr = cf.clr_sel ? s.ctrl.aclr1 : s.ctrl.aclr0;
      unique case (cf.ff)
        ple_pkg::FF_D: begin
          nq = din;
        end
        ple_pkg::FF_T: begin
          nq = s.q[i] ^ din;
        end
        ple_pkg::FF_JK: begin
          nq = (din & ~s.q[i]) | (~d[2] & s.q[i]);
        end
        ple_pkg::FF_SR: begin
          nq = din | (s.q[i] & ~d[2]);
        end
      endcase

      // asynchronous controls act at the next edge here, single clock design
      if (pin_hit) begin
        n.q[i] = 1'b0;
      end else if (s.ctrl.reinit) begin
        n.q[i] = cf.pwr_hi;
      end else if (clr) begin
        n.q[i] = 1'b0;
      end else if (s.ctrl.preset) begin
        n.q[i] = 1'b1;
      end else if (s.ctrl.aload) begin
        n.q[i] = fourth_data_input;
      end else if (ce) begin
        if (s.ctrl.sclr) begin
          n.q[i] = 1'b0;
        end else if (s.ctrl.sload) begin
          n.q[i] = fourth_data_input;
        end else begin
          n.q[i] = nq;
        end
      end

      for (int k = 0; k < 3; k++) begin
        n.gen[3*i+k] = cf.osel[k] ? s.q[i] : res;
      end
      n.comb[i]           = res;
      pq                  = s.q[i];
      pl                  = res;
      carry_in_zero_chain = carry_out_zero_chain;
      carry_in_one_chain  = carry_out_one_chain;
    end
    // tenth cell: block carry picks the chain leaving the group
    n.cout   = blk ? carry_in_one_chain : carry_in_zero_chain;
    n.lchain = pl;
    n.rchain = s.q[ple_pkg::NCELL-1];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= ple_pkg::ST_RST;
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign dat_o       = s.dat;
  assign ack_o       = s.ack;
  assign gen_o       = s.gen;
  assign comb_o      = s.comb;
  assign q_o         = s.q;
  assign lut_chain_o = s.lchain;
  assign reg_chain_o = s.rchain;
  assign carry_out_o = s.cout;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_chip_clear_all: assert property (@(posedge clk_i) disable iff (rst_i)
    pin_hit |=> (s.q == '0))
    else $error("chip clear did not clear registers");

  chk_clear_wins: assert property (@(posedge clk_i) disable iff (rst_i)
    (!pin_hit && !s.ctrl.reinit && s.ctrl.aclr0 && !s.cfg[0].clr_sel && s.ctrl.preset)
    |=> !s.q[0])
    else $error("preset won over clear");

  chk_preset_high: assert property (@(posedge clk_i) disable iff (rst_i)
    (!pin_hit && !s.ctrl.reinit && !s.ctrl.aclr0 && !s.ctrl.aclr1 && s.ctrl.preset)
    |=> (&s.q))
    else $error("preset did not load high");

  chk_reg_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (!pin_hit && !s.ctrl.reinit && !s.ctrl.aclr0 && !s.ctrl.aclr1 && !s.ctrl.preset
     && !s.ctrl.aload && !s.ctrl.ce0 && !s.ctrl.ce1) |=> $stable(s.q))
    else $error("register changed without enable");

  chk_sync_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (!pin_hit && !s.ctrl.reinit && !s.ctrl.aclr0 && !s.ctrl.aclr1 && !s.ctrl.preset
     && !s.ctrl.aload && s.ctrl.ce0 && s.ctrl.ce1 && s.ctrl.sclr && !s.cfg[0].cnt)
    |=> !s.q[0])
    else $error("sync clear missed");

  chk_sub_carry: assert property (@(posedge clk_i) disable iff (rst_i)
    s.ctrl.sub |-> grp_cin)
    else $error("subtract did not force carry-in");

  chk_gen_select: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(s.cfg[0].osel[0]) |-> (s.gen[0] == $past(s.q[0])))
    else $error("output did not follow register");

  chk_reg_chain: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> (reg_chain_o == $past(s.q[9])))
    else $error("register chain out wrong");

  // ----------------------------------------
  // bus and control checks
  // ----------------------------------------
  chk_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack stood longer than one cycle");

  chk_req_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && !ack_o) |=> ack_o)
    else $error("request not acknowledged");

  chk_idle_dat: assert property (@(posedge clk_i) disable iff (rst_i)
    !s.ack |-> (s.dat == ple_pkg::RD_ZERO))
    else $error("read data not zero outside ack");

  chk_reinit_self: assert property (@(posedge clk_i) disable iff (rst_i)
    s.ctrl.reinit |=> !s.ctrl.reinit)
    else $error("reinit did not clear itself");

  chk_reinit_load: assert property (@(posedge clk_i) disable iff (rst_i)
    (!pin_hit && s.ctrl.reinit) |=> (s.q[0] == $past(s.cfg[0].pwr_hi)))
    else $error("reinit did not load power-up level");

  chk_aload_data: assert property (@(posedge clk_i) disable iff (rst_i)
    (!pin_hit && !s.ctrl.reinit && !s.ctrl.aclr0 && !s.ctrl.aclr1 && !s.ctrl.preset && s.ctrl.aload)
    |=> (s.q[0] == $past(data_i[3])))
    else $error("load did not take fourth input");

  chk_sync_load: assert property (@(posedge clk_i) disable iff (rst_i)
    (!pin_hit && !s.ctrl.reinit && !s.ctrl.aclr0 && !s.ctrl.aclr1 && !s.ctrl.preset && !s.ctrl.aload
     && s.ctrl.ce0 && !s.cfg[0].ce_sel && !s.cfg[0].cnt && !s.ctrl.sclr && s.ctrl.sload)
    |=> (s.q[0] == $past(data_i[3])))
    else $error("sync load missed");

  chk_clear1_wins: assert property (@(posedge clk_i) disable iff (rst_i)
    (!pin_hit && !s.ctrl.reinit && s.ctrl.aclr1 && s.cfg[0].clr_sel) |=> !s.q[0])
    else $error("second clear did not clear");

  chk_gen_result: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(s.cfg[0].osel[1]) |-> (s.gen[1] == s.comb[0]))
    else $error("output did not follow result");

  chk_gen_reg2: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(s.cfg[0].osel[2]) |-> (s.gen[2] == $past(s.q[0])))
    else $error("third output did not follow register");

  chk_first_carry: assert property (@(posedge clk_i) disable iff (rst_i)
    (s.ctrl.sub && s.cfg[0].arith && !s.cfg[0].cnt)
    |=> (s.comb[0] == ($past(data_i[1]) ^ $past(data_i[2]))))
    else $error("subtract lsb wrong");

endmodule

// ### verif/ple_nbr.sv
// partner model: previous logic cell group and chip clear pin driver
`timescale 1ns/100ps
module ple_nbr (
  input  wire logic       clk_i,   // fabric clock
  input  wire logic       rst_i,   // sync reset, high
  input  wire logic [3:0] set_i,   // {clear_n, reg chain, table chain, carry}
  output logic            carry_o, // carry from previous group
  output logic            lch_o,   // table chain into cell 0
  output logic            rch_o,   // register chain into cell 0
  output logic            clr_n_o  // chip clear pin, low
);
  // ----------------------------------------
  // registered like a real neighbour group
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    carry_o <= rst_i ? 1'b0 : set_i[0];
    lch_o   <= rst_i ? 1'b0 : set_i[1];
    rch_o   <= rst_i ? 1'b0 : set_i[2];
    clr_n_o <= rst_i ? 1'b0 : set_i[3];
  end
endmodule

// ### verif/programmable_logic_element_test.sv
// testbench: logic cell group through wishbone and fabric ports
`timescale 1ns/100ps
module programmable_logic_element_test;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [39:0] data = 40'h00_0000_0000;
  logic [3:0]  nset = 4'h8;
  logic [31:0] rdat;
  logic        ack;
  logic        cin;
  logic        lch;
  logic        rch;
  logic        clr_n;
  logic [29:0] gen;
  logic [9:0]  comb;
  logic [9:0]  q;
  logic        cout;
  logic        lco;
  logic        rco;
  int          err_total = 0;
  int          total_checks = 0;
  ple_pkg::ple_cfg_t c;

  always #20 clk = ~clk;

  ple_nbr nbr (.clk_i(clk), .rst_i(rst), .set_i(nset), .carry_o(cin), .lch_o(lch), .rch_o(rch), .clr_n_o(clr_n));
  ple_cell_group dut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .data_i(data), .carry_in_i(cin), .lut_chain_i(lch),
    .reg_chain_i(rch), .chip_wide_clear_n_i(clr_n), .gen_o(gen), .comb_o(comb), .q_o(q),
    .lut_chain_o(lco), .reg_chain_o(rco), .carry_out_o(cout));

  // ----------------------------------------
  // shared bus and compare tasks
  // ----------------------------------------
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= 4'hf;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    r = rdat;
    if (n >= 50) err_total++;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk);
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, s);
      err_total++;
    end
  endtask

  task automatic ctl(input logic [31:0] v);
    logic [31:0] r;
    wb(1'b1, ple_pkg::A_CTRL, v, r);
  endtask

  task automatic cfg(input int i, input ple_pkg::ple_cfg_t v);
    logic [31:0] r;
    wb(1'b1, ple_pkg::A_CFG + 8'(4 * i), v, r);
  endtask

  // result lands one edge late, so allow a margin of edges
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    logic [31:0] r;
    wb(1'b0, ple_pkg::A_CTRL, 32'h0000_0000, r);
    chk("ctrl reset", 32'h0000_0000, r);
    wb(1'b1, 8'h80, 32'hffff_ffff, r);
    wb(1'b0, 8'h80, 32'h0000_0000, r);
    chk("unmapped", 32'h0000_0000, r);
    ctl(32'hffff_f800);
    wb(1'b0, ple_pkg::A_CTRL, 32'h0000_0000, r);
    chk("ctrl reserved", 32'h0000_0000, r);
    wb(1'b1, ple_pkg::A_STAT, 32'hffff_ffff, r);
    wb(1'b0, ple_pkg::A_STAT, 32'h0000_0000, r);
    chk("status", 32'h0001_0000, r);
    $display("test regs done");
  endtask

  task automatic t_lut();
    c = '0;
    c.mask = 16'h6996;
    cfg(0, c);
    for (int v = 0; v < 16; v++) begin
      data[3:0] <= 4'(v);
      settle();
      chk("parity", {31'h0, ^4'(v)}, {31'h0, comb[0]});
    end
    c.mask = 16'h8000;
    cfg(0, c);
    c.mask = 16'haaaa;
    c.lchain = 1'b1;
    cfg(1, c);
    data[3:0] <= 4'hf;
    settle();
    chk("table chain", 32'h0000_0001, {31'h0, comb[1]});
    $display("test lut done");
  endtask

  task automatic t_ff();
    logic s;
    for (int f = 0; f < 4; f++) begin
      c = '0;
      c.mask = 16'haaaa;
      c.osel = 3'h5;
      c.ff = ple_pkg::ple_ff_t'(f);
      cfg(0, c);
      ctl(32'h0000_0002);
      data[3:0] <= 4'h1;
      settle();
      if (f == 1) begin
        s = q[0];
        @(posedge clk);
        chk("toggle", {31'h0, ~s}, {31'h0, q[0]});
      end else begin
        chk("set q", 32'h0000_0001, {31'h0, q[0]});
        chk("gen all", 32'h0000_0007, {29'h0, gen[2:0]});
        data[3:0] <= 4'h4;
        settle();
        chk("reset q", 32'h0000_0000, {31'h0, q[0]});
      end
    end
    ctl(32'h0000_0000);
    data[3:0] <= 4'h1;
    settle();
    chk("hold q", 32'h0000_0000, {31'h0, q[0]});
    chk("split gen", 32'h0000_0002, {29'h0, gen[2:0]});
    $display("test ff done");
  endtask

  task automatic t_clr();
    logic [31:0] r;
    c = '0;
    cfg(0, c);
    ctl(32'h0000_0080);
    settle();
    chk("preset", 32'h0000_0001, {31'h0, q[0]});
    chk("reg chain out", 32'h0000_0001, {31'h0, rco});
    ctl(32'h0000_00a0);
    settle();
    chk("clear wins", 32'h0000_0000, {31'h0, q[0]});
    ctl(32'h0000_00c0);
    settle();
    chk("other clear", 32'h0000_0001, {31'h0, q[0]});
    nset <= 4'h0;
    ctl(32'h0000_0280);
    settle();
    chk("pin clear", 32'h0000_0000, {31'h0, q[0]});
    wb(1'b0, ple_pkg::A_STAT, 32'h0000_0000, r);
    chk("pin level", 32'h0000_0000, {31'h0, r[16]});
    nset <= 4'h8;
    ctl(32'h0000_0000);
    $display("test clear done");
  endtask

  task automatic t_sum(input logic [9:0] a, input logic [9:0] b, input logic sub, input logic ci);
    logic [39:0] d;
    logic [10:0] e;
    d = '0;
    for (int i = 0; i < 10; i++) begin
      d[4 * i + 1] = a[i];
      d[4 * i + 2] = b[i];
    end
    e = sub ? {1'b0, a} + {1'b0, ~b} + 11'h001 : {1'b0, a} + {1'b0, b} + {10'h0, ci};
    nset <= {3'h4, ci};
    data <= d;
    ctl({31'h0, sub});
    settle();
    chk("sum", {22'h0, e[9:0]}, {22'h0, comb});
    chk("carry out", {31'h0, e[10]}, {31'h0, cout});
    chk("table chain out", {31'h0, e[9]}, {31'h0, lco});
  endtask

  task automatic t_misc();
    c = '0;
    c.pwr_hi = 1'b1;
    cfg(0, c);
    ctl(32'h0000_0400);
    settle();
    chk("power-up level", 32'h0000_0001, {30'h0, q[1:0]});
    data <= 40'h00_0000_0080;
    ctl(32'h0000_0100);
    settle();
    chk("async load", 32'h0000_0002, {30'h0, q[1:0]});
    ctl(32'h0000_0000);
    $display("test misc done");
  endtask

  task automatic t_arith();
    for (int i = 0; i < 10; i++) begin
      c = '0;
      c.arith = 1'b1;
      c.start = (i == 0);
      cfg(i, c);
    end
    t_sum(10'h005, 10'h003, 1'b0, 1'b0);
    t_sum(10'h005, 10'h003, 1'b1, 1'b0);
    t_sum(10'h003, 10'h005, 1'b1, 1'b0);
    t_sum(10'h3ff, 10'h001, 1'b0, 1'b0);
    t_sum(10'h005, 10'h003, 1'b0, 1'b1);
    $display("test arith done");
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_lut();
    t_ff();
    t_clr();
    t_arith();
    t_misc();
    results();
  end

  // whole run needs well under two thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    results();
  end
endmodule
